// ==== rtl/rcpv_pkg.sv ====
// package: constants and types for the reset cause and program counter vector block
package rcpv_pkg;
    // register map, word addresses on the register port
    localparam logic [7:0] RCPV_ADDR_STATUS  = 8'h03;
    localparam logic [7:0] RCPV_ADDR_FSP     = 8'h04;
    localparam logic [7:0] RCPV_ADDR_IRQ_ST  = 8'h10;
    localparam logic [7:0] RCPV_ADDR_IRQ_MSK = 8'h11;
    localparam logic [7:0] RCPV_ADDR_CAUSE   = 8'h12;
    localparam logic [7:0] RCPV_ADDR_PC_LO   = 8'h13;
    localparam logic [7:0] RCPV_ADDR_PC_HI   = 8'h14;
    localparam logic [7:0] RCPV_ADDR_CTRL    = 8'h15;

    // status register field positions
    localparam int RCPV_ST_PAGE_LSB = 5;
    localparam int RCPV_ST_TO       = 4;
    localparam int RCPV_ST_PD       = 3;
    localparam int RCPV_ST_ZERO     = 2;
    localparam int RCPV_ST_DC       = 1;
    localparam int RCPV_ST_CARRY    = 0;

    // file select pointer bank field
    localparam int RCPV_FSP_BANK_LSB = 5;

    // power-on value of the status register, arithmetic bits zero
    localparam logic [7:0] RCPV_STATUS_POR = 8'h18;

    // interrupt event bit positions
    localparam int RCPV_EV_POR    = 0;
    localparam int RCPV_EV_CLR    = 1;
    localparam int RCPV_EV_CLRWK  = 2;
    localparam int RCPV_EV_WDT    = 3;
    localparam int RCPV_EV_WDTWK  = 4;
    localparam int RCPV_EV_W      = 5;

    // control register bit: request core halt
    localparam int RCPV_CTRL_HALT = 0;

    // reset causes
    typedef enum logic [4:0] {
        RCPV_CAUSE_POR   = 5'h01,
        RCPV_CAUSE_CLR   = 5'h02,
        RCPV_CAUSE_CLRWK = 5'h04,
        RCPV_CAUSE_WDT   = 5'h08,
        RCPV_CAUSE_WDTWK = 5'h10
    } rcpv_cause_t;

    // core sequencing states
    typedef enum logic [2:0] {
        RCPV_ST_HOLD = 3'h1,
        RCPV_ST_RUN  = 3'h2,
        RCPV_ST_HLT  = 3'h4
    } rcpv_state_t;

    // reset source bundle
    typedef struct packed {
        logic power_on;
        logic external_clear_input;
        logic watchdog_timer;
    } rcpv_src_t;

    // register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } rcpv_req_t;
endpackage

// ==== rtl/rcpv_top.sv ====
// module: reset merge, cause flags, status register and program counter vector
//
// The strobed register port was decided locally.
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module rcpv_top
#(
    parameter int PC_W     = 9,
    parameter int BANK_W   = 0
)
(
    // clock and reset
    input  wire logic                 i_ref_clk,
    input  wire logic                 i_reset,
    // reset sources
    input  wire rcpv_pkg::rcpv_src_t  i_src,
    // core side
    input  wire logic                 i_sleep_req,
    input  wire logic                 i_fetch_adv,
    input  wire logic                 i_branch,
    input  wire logic [PC_W-1:0]      i_branch_addr,
    input  wire logic [2:0]           i_alu_flags,
    input  wire logic                 i_alu_flags_we,
    // register port
    input  wire rcpv_pkg::rcpv_req_t  i_req,
    output logic [7:0]                o_rdata,
    // outputs
    output logic                      o_core_reset,
    output logic                      o_halted,
    output logic [PC_W-1:0]           o_program_counter,
    output logic [7:0]                o_status_flags,
    output logic [1:0]                o_page_select,
    output logic [2:0]                o_bank_select,
    output logic                      o_irq
);
    import rcpv_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // elaboration checks
    initial
    begin
        if (PC_W < 9 || PC_W > 11)
            $error("program counter width must be 9 to 11");
        if (BANK_W < 0 || BANK_W > 3)
            $error("bank width must be 0 to 3");
    end

    localparam logic [PC_W-1:0] PC_VECTOR = {PC_W{1'b1}};
    localparam logic [PC_W-1:0] PC_ONE    = {{(PC_W-1){1'b0}}, 1'b1};

    ////////////////////////////////////////////////////////////////////////////
    // registers
    rcpv_state_t      state;
    logic [7:0]       status_flags;
    logic [7:0]       file_select_pointer;
    logic [PC_W-1:0]  program_counter;
    logic [4:0]       irq_status;
    logic [4:0]       irq_mask;
    logic [4:0]       last_cause;
    logic             halt_ctrl;
    logic             por_seen;
    logic             src_d;

    ////////////////////////////////////////////////////////////////////////////
    // reset source decode
    wire  in_halt    = (state == RCPV_ST_HLT);
    wire  por_ev     = i_src.power_on | ~por_seen;
    wire  clr_ev     = i_src.external_clear_input & ~por_ev;
    wire  wdt_ev     = i_src.watchdog_timer & ~por_ev & ~i_src.external_clear_input;
    wire  any_src    = i_src.power_on | i_src.external_clear_input
                     | i_src.watchdog_timer | ~por_seen;
    wire  src_start  = any_src & ~src_d;
    wire  wake_clr   = clr_ev & in_halt;
    wire  wake_wdt   = wdt_ev & in_halt;

    wire [4:0] cause_now =
        por_ev   ? RCPV_CAUSE_POR :
        wake_clr ? RCPV_CAUSE_CLRWK :
        clr_ev   ? RCPV_CAUSE_CLR :
        wake_wdt ? RCPV_CAUSE_WDTWK : RCPV_CAUSE_WDT;

    // cause flag values per reset kind
    wire next_to = por_ev   ? 1'b1 :
                   wake_clr ? 1'b1 :
                   clr_ev   ? status_flags[RCPV_ST_TO] :
                   1'b0;
    wire next_pd = por_ev   ? 1'b1 :
                   wake_clr ? 1'b0 :
                   clr_ev   ? status_flags[RCPV_ST_PD] :
                   wake_wdt ? 1'b0 : 1'b1;

    // status image under reset: page bits clear, arithmetic kept except on power-on, which loads RCPV_STATUS_POR
    wire [7:0] status_rst = por_ev ? RCPV_STATUS_POR
                          : {3'b000, next_to, next_pd, status_flags[2:0]};

    ////////////////////////////////////////////////////////////////////////////
    // register port decode
    wire  wr_status = i_req.wr & (i_req.addr == RCPV_ADDR_STATUS);
    wire  wr_fsp    = i_req.wr & (i_req.addr == RCPV_ADDR_FSP);
    wire  wr_irq_st = i_req.wr & (i_req.addr == RCPV_ADDR_IRQ_ST);
    wire  wr_irq_mk = i_req.wr & (i_req.addr == RCPV_ADDR_IRQ_MSK);
    wire  wr_ctrl   = i_req.wr & (i_req.addr == RCPV_ADDR_CTRL);
    wire  wr_pcl    = i_req.wr & (i_req.addr == RCPV_ADDR_PC_LO);

    // flags are read-only to software: only page and arithmetic bits writable
    wire [7:0] status_wr = {i_req.wdata[7:5], status_flags[RCPV_ST_TO],
                            status_flags[RCPV_ST_PD], i_req.wdata[2:0]};

    wire [15:0] pc_wide = {{(16-PC_W){1'b0}}, program_counter};

    wire [7:0] rd_mux =
        (i_req.addr == RCPV_ADDR_STATUS)  ? status_flags :
        (i_req.addr == RCPV_ADDR_FSP)     ? file_select_pointer :
        (i_req.addr == RCPV_ADDR_IRQ_ST)  ? {3'b000, irq_status} :
        (i_req.addr == RCPV_ADDR_IRQ_MSK) ? {3'b000, irq_mask} :
        (i_req.addr == RCPV_ADDR_CAUSE)   ? {3'b000, last_cause} :
        (i_req.addr == RCPV_ADDR_PC_LO)   ? pc_wide[7:0] :
        (i_req.addr == RCPV_ADDR_PC_HI)   ? pc_wide[15:8] :
        (i_req.addr == RCPV_ADDR_CTRL)    ? {7'h00, halt_ctrl} : 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // program counter: increment wraps in the implemented width
    wire [PC_W-1:0] pc_inc = program_counter + PC_ONE;

    // page bits feed the upper counter bits on large stores
    wire [1:0] page_bits = status_flags[RCPV_ST_PAGE_LSB +: 2];
    wire [PC_W-1:0] branch_paged;
    generate
        if (PC_W > 9)
        begin : g_paged
            assign branch_paged = {page_bits[PC_W-10:0], i_branch_addr[8:0]};
        end
        else
        begin : g_flat
            assign branch_paged = i_branch_addr;
        end
    endgenerate

    wire [PC_W-1:0] pc_load = {pc_wide[PC_W-1:8], i_req.wdata};

    wire [PC_W-1:0] next_pc =
        wr_pcl      ? pc_load :
        i_branch    ? branch_paged :
        i_fetch_adv ? pc_inc : program_counter;

    // a mask write takes effect on the interrupt in the same edge
    wire [4:0] next_irq_mask = wr_irq_mk ? i_req.wdata[4:0] : irq_mask;

    // sticky event set wins over write-one clear
    wire [4:0] next_irq_status =
        (irq_status & ~(wr_irq_st ? i_req.wdata[4:0] : 5'h00))
        | (src_start ? cause_now : 5'h00);

    ////////////////////////////////////////////////////////////////////////////
    // sequencer and registers
    always_ff @(posedge i_ref_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            state               <= RCPV_ST_HOLD;
            status_flags        <= RCPV_STATUS_POR;
            file_select_pointer <= 8'h00;
            program_counter     <= PC_VECTOR;
            irq_status          <= 5'h00;
            irq_mask            <= 5'h00;
            last_cause          <= 5'h00;
            halt_ctrl           <= 1'b0;
            por_seen            <= 1'b0;
            src_d               <= 1'b0;
        end
        else
        begin
            src_d    <= any_src;
            por_seen <= 1'b1;
            irq_status <= next_irq_status;
            if (wr_irq_mk)
                irq_mask <= i_req.wdata[4:0];
            if (any_src)
            begin
                // every warm reset restarts the core from the vector
                state           <= RCPV_ST_HOLD;
                // flags taken once per source: a held source does not re-judge, except a held power-on, which reloads every cycle
                if (src_start || por_ev)
                begin
                    status_flags <= status_rst;
                    last_cause   <= cause_now;
                end
                program_counter <= PC_VECTOR;
                halt_ctrl       <= 1'b0;
                // pointer is unaffected by warm resets
                if (por_ev)
                    file_select_pointer <= 8'h00;
            end
            else
            begin
                unique case (state)
                    RCPV_ST_HOLD: state <= RCPV_ST_RUN;
                    RCPV_ST_RUN:
                        if (i_sleep_req || (wr_ctrl && i_req.wdata[RCPV_CTRL_HALT]))
                        begin
                            state  <= RCPV_ST_HLT;
                            // entering halt: timeout set, powerdown cleared
                            status_flags[RCPV_ST_TO] <= 1'b1;
                            status_flags[RCPV_ST_PD] <= 1'b0;
                        end
                    RCPV_ST_HLT: state <= RCPV_ST_HLT;        // only a reset leaves
                endcase
                if (state == RCPV_ST_RUN)
                begin
                    program_counter <= next_pc;
                    if (wr_status)
                        status_flags <= status_wr;
                    else if (i_alu_flags_we)
                        status_flags[2:0] <= i_alu_flags;
                end
                if (wr_fsp)
                    file_select_pointer <= i_req.wdata;
                if (wr_ctrl)
                    halt_ctrl <= i_req.wdata[RCPV_CTRL_HALT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registered outputs
    wire [2:0] bank_now;
    generate
        if (BANK_W > 0)
        begin : g_bank
            assign bank_now = {{(3-BANK_W){1'b0}},
                file_select_pointer[RCPV_FSP_BANK_LSB +: BANK_W]};
        end
        else
        begin : g_nobank
            assign bank_now = 3'b000;
        end
    endgenerate

    always_ff @(posedge i_ref_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            o_rdata           <= 8'h00;
            o_core_reset      <= 1'b1;
            o_halted          <= 1'b0;
            o_program_counter <= PC_VECTOR;
            o_status_flags    <= RCPV_STATUS_POR;
            o_page_select     <= 2'b00;
            o_bank_select     <= 3'b000;
            o_irq             <= 1'b0;
        end
        else
        begin
            o_rdata           <= i_req.rd ? rd_mux : 8'h00;
            o_core_reset      <= any_src | (state == RCPV_ST_HOLD);
            o_halted          <= in_halt;
            o_program_counter <= program_counter;
            o_status_flags    <= status_flags;
            o_page_select     <= (PC_W > 9) ? page_bits : 2'b00;
            o_bank_select     <= bank_now;
            o_irq             <= |(next_irq_status & next_irq_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // assertions
    sequence s_por_pulse;
        i_src.power_on;
    endsequence

    AST_POR_FLAGS: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        s_por_pulse |=> status_flags[4:3] == 2'b11)
        else $error("power-on did not set both flags");
    AST_CLR_KEEP: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (clr_ev && !in_halt) |=> status_flags[4:3] == $past(status_flags[4:3]))
        else $error("clear reset changed cause flags");
    AST_CLR_WAKE: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (wake_clr && src_start) |=> status_flags[4:3] == 2'b10)
        else $error("clear wake flags wrong");
    AST_WDT_RUN: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (wdt_ev && !in_halt && src_start) |=> status_flags[4:3] == 2'b01)
        else $error("watchdog reset flags wrong");
    AST_WDT_WAKE: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (wake_wdt && src_start) |=> status_flags[4:3] == 2'b00 && state == RCPV_ST_HOLD)
        else $error("watchdog wake flags wrong");
    AST_VECTOR: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        any_src |=> program_counter == PC_VECTOR && status_flags[7:5] == 3'b000)
        else $error("reset did not load vector");
    AST_WRAP: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (state == RCPV_ST_RUN && !any_src && !wr_pcl && !i_branch && i_fetch_adv
         && program_counter == PC_VECTOR) |=> program_counter == '0)
        else $error("vector increment did not wrap");
    AST_RELEASE: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        $fell(any_src) |=> o_core_reset ##1 !o_core_reset)
        else $error("core reset release timing wrong");
endmodule // rcpv_top

`default_nettype wire

// ==== verif/rcpv_src_model.sv ====
// reset source model: power-on detector, clear pin and watchdog level requests
`timescale 1ns/100ps
`default_nettype none
module rcpv_src_model
(
    // clock
    input  wire logic                i_ref_clk,
    // request from the bench
    input  wire logic [1:0]          i_kind,
    input  wire logic                i_go,
    input  wire logic [3:0]          i_len,
    // reset source lines
    output var rcpv_pkg::rcpv_src_t  o_src
);
    import rcpv_pkg::*;
    logic [3:0] remain = 4'h0;
    logic [1:0] kind_q = 2'h3;
    ////////////////////////////////////////////////////////////////////////////////
    // length in cycles lets a source be short or held long
    always_ff @(posedge i_ref_clk)
    begin
        if (i_go)
        begin
            remain <= i_len;
            kind_q <= i_kind;
        end
        else if (remain != 4'h0)
            remain <= remain - 4'h1;
    end
    // released lines drop to their inactive level, never stay at the last value
    always_comb
    begin
        o_src.power_on             = (remain != 4'h0) && (kind_q == 2'h0);
        o_src.external_clear_input = (remain != 4'h0) && (kind_q == 2'h1);
        o_src.watchdog_timer       = (remain != 4'h0) && (kind_q == 2'h2);
    end
endmodule // rcpv_src_model
`default_nettype wire

// ==== verif/rcpv_top_bench.sv ====
// testbench: reset causes, cause flags, vector load and register port
`timescale 1ns/100ps
`default_nettype none
module rcpv_top_bench;
    import rcpv_pkg::*;
    typedef struct packed {
        logic [1:0] kind;
        logic       sleep;
        logic [1:0] flags;
        logic [7:0] cause;
    } rcpv_row_t;
    logic       i_ref_clk;
    logic       i_reset;
    rcpv_src_t  src;
    logic       sleep_req, fetch_adv, branch, alu_we, go;
    logic [8:0] branch_addr;
    logic [2:0] alu_flags;
    logic [1:0] kind;
    logic [3:0] len;
    rcpv_req_t  req;
    logic [7:0] o_rdata, o_status_flags, rd_val;
    logic       o_core_reset, o_halted, o_irq;
    logic [8:0] o_program_counter;
    logic [1:0] o_page_select;
    logic [2:0] o_bank_select;
    int         errors, total_checks, cycles;
    // flags column is {timeout, powerdown}
    rcpv_row_t  rows [5] = '{'{2'h2, 1'b0, 2'b01, 8'h08}, '{2'h1, 1'b0, 2'b01, 8'h02},
                             '{2'h1, 1'b1, 2'b10, 8'h04}, '{2'h2, 1'b1, 2'b00, 8'h10},
                             '{2'h1, 1'b0, 2'b00, 8'h02}};
    ////////////////////////////////////////////////////////////////////////////////
    rcpv_src_model i_src_model (.i_ref_clk(i_ref_clk), .i_kind(kind), .i_go(go),
                                .i_len(len), .o_src(src));
    rcpv_top #(.PC_W(9), .BANK_W(0)) i_dut (
        .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_src(src), .i_sleep_req(sleep_req),
        .i_fetch_adv(fetch_adv), .i_branch(branch), .i_branch_addr(branch_addr),
        .i_alu_flags(alu_flags), .i_alu_flags_we(alu_we), .i_req(req), .o_rdata(o_rdata),
        .o_core_reset(o_core_reset), .o_halted(o_halted),
        .o_program_counter(o_program_counter), .o_status_flags(o_status_flags),
        .o_page_select(o_page_select), .o_bank_select(o_bank_select), .o_irq(o_irq));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_ref_clk);
        req.addr  <= a;
        req.wdata <= d;
        req.wr    <= 1'b1;
        @(posedge i_ref_clk);
        req.wr    <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        @(posedge i_ref_clk);
        req.addr <= a;
        req.rd   <= 1'b1;
        @(posedge i_ref_clk);
        req.rd   <= 1'b0;
        #1;
        rd_val = o_rdata;
    endtask
    // bounded wait: a stuck core reset shows up as a mismatch, not a hang
    task automatic fire(input logic [1:0] k, input logic [3:0] n);
        int w;
        w = 0;
        @(posedge i_ref_clk);
        kind <= k;
        len  <= n;
        go   <= 1'b1;
        @(posedge i_ref_clk);
        go   <= 1'b0;
        @(posedge i_ref_clk);
        #1 chk("core reset held", 16'(o_core_reset), 16'(k != 2'h3));
        while (o_core_reset === 1'b1 && w < 40)
        begin
            @(posedge i_ref_clk);
            #1 w++;
        end
        chk("core reset released", 16'(o_core_reset), 16'h0);
        chk("vector", 16'(o_program_counter), 16'h01ff);
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        i_ref_clk = 1'b0;
        forever #5 i_ref_clk = ~i_ref_clk;
    end
    initial
    begin
        cycles = 0;
        forever
        begin
            @(posedge i_ref_clk);
            cycles++;
            if (cycles >= 5000)
            begin
                errors++;
                close_out();
            end
        end
    end
    initial
    begin
        {sleep_req, fetch_adv, branch, alu_we, go} = 5'h00;
        {branch_addr, alu_flags, kind, len, req} = '0;
        errors = 0;
        total_checks = 0;
        i_reset = 1'b1;
        repeat (12) @(posedge i_ref_clk);
        i_reset <= 1'b0;
        @(posedge i_ref_clk);
        #1 chk("status at power-on", 16'(o_status_flags), 16'h0018);
        chk("core reset after release", 16'(o_core_reset), 16'h1);
        fire(2'h3, 4'h0);
        $display("test power-on done");
        @(posedge i_ref_clk);
        branch      <= 1'b1;
        branch_addr <= 9'h1fe;
        @(posedge i_ref_clk);
        branch    <= 1'b0;
        fetch_adv <= 1'b1;
        repeat (2) @(posedge i_ref_clk);
        fetch_adv <= 1'b0;
        repeat (2) @(posedge i_ref_clk);
        #1 chk("wrap to zero", 16'(o_program_counter), 16'h0000);
        wr_reg(RCPV_ADDR_FSP, 8'h3c);
        wr_reg(RCPV_ADDR_IRQ_ST, 8'h1f);
        wr_reg(RCPV_ADDR_IRQ_MSK, 8'h1f);
        $display("test wrap done");
        foreach (rows[i])
        begin
            wr_reg(RCPV_ADDR_STATUS, 8'he0);
            @(posedge i_ref_clk);
            alu_flags <= 3'b101;
            alu_we    <= 1'b1;
            @(posedge i_ref_clk);
            alu_we    <= 1'b0;
            if (rows[i].sleep)
            begin
                sleep_req <= 1'b1;
                @(posedge i_ref_clk);
                sleep_req <= 1'b0;
                repeat (2) @(posedge i_ref_clk);
                #1 chk("halted", 16'(o_halted), 16'h1);
            end
            fire(rows[i].kind, 4'(3 + i));
            chk("running after wake", 16'(o_halted), 16'h0);
            chk("status", 16'(o_status_flags), 16'({3'b000, rows[i].flags, 3'b101}));
            rd_reg(RCPV_ADDR_CAUSE);
            chk("cause", 16'(rd_val), 16'(rows[i].cause));
            rd_reg(RCPV_ADDR_FSP);
            chk("kept pointer", 16'(rd_val), 16'h003c);
            chk("irq raised", 16'(o_irq), 16'h1);
            wr_reg(RCPV_ADDR_IRQ_ST, 8'h1f);
            @(posedge i_ref_clk);
            #1 chk("irq cleared", 16'(o_irq), 16'h0);
            $display("test cause row %0d done", i);
        end
        wr_reg(RCPV_ADDR_IRQ_MSK, 8'h00);
        fire(2'h1, 4'h2);
        chk("irq masked", 16'(o_irq), 16'h0);
        wr_reg(RCPV_ADDR_IRQ_MSK, 8'h1f);
        #1 chk("irq unmasked", 16'(o_irq), 16'h1);
        rd_reg(8'h20);
        chk("unmapped read", 16'(rd_val), 16'h0000);
        $display("test interrupt done");
        fire(2'h0, 4'h4);
        chk("power-on flags", 16'(o_status_flags[7:3]), 16'h0003);
        rd_reg(RCPV_ADDR_FSP);
        chk("pointer after power-on", 16'(rd_val), 16'h0000);
        $display("test power-on source done");
        close_out();
    end
endmodule // rcpv_top_bench
`default_nettype wire
